// ===== rtl/mmu_map.svh
// Address map, reset values and field positions of the address translation unit.
`ifndef MMU_MAP_SVH
`define MMU_MAP_SVH

// I/O addresses of the three translation registers.
`define MMU_HIGH_BASE_ADDR 16'h0038
`define MMU_BANK_BASE_ADDR 16'h0039
`define MMU_AREA_ADDR 16'h003A

// Reset values of the translation registers.
`define MMU_HIGH_BASE_RST 8'h00
`define MMU_BANK_BASE_RST 8'h00
`define MMU_AREA_RST 8'hF0

// Field positions inside the area boundary register.
`define MMU_HI_START_MSB 7
`define MMU_HI_START_LSB 4
`define MMU_BANK_START_MSB 3
`define MMU_BANK_START_LSB 0

// Logical address split: the upper nibble selects the 4K page.
`define MMU_PAGE_MSB 15
`define MMU_PAGE_LSB 12
`define MMU_OFFS_MSB 11
`define MMU_OFFS_LSB 0

// Constants used when forming physical addresses.
`define MMU_NIB_PAD 4'h0
`define MMU_IO_TOP 4'h0
`define MMU_LOW_BASE 8'h00
`define MMU_PHYS_RST 20'h00000
`define MMU_DATA_RST 8'h00

`endif

// ===== rtl/mmu_pkg.sv
// Types shared by the address translation unit and its area comparator.
package mmu_pkg;

    // The three logical areas that an access can fall in.
    typedef enum logic [1:0] {
        AREA_LOW_COMMON,
        AREA_BANK,
        AREA_HIGH_COMMON
    } area_t;

    // Whole state of the translation unit.
    typedef struct packed {
        logic [7:0] high_base;   // High common base value.
        logic [7:0] bank_base;   // Bank area base value.
        logic [7:0] area;        // Area boundary value.
        logic [19:0] phys;       // Physical address driven on the bus.
        logic [7:0] rdata;       // Register read data.
        logic rvalid;            // Read data valid pulse.
    } mmu_state_t;

endpackage

// ===== rtl/mmu_xlate_if.sv
// Interface between the translation unit and its area comparator.
`timescale 1ns/1ps
`default_nettype none

interface mmu_xlate_if;
    logic [3:0] nibble;         // Upper logical address nibble.
    logic [7:0] area;           // Area boundary register contents.
    logic [7:0] high_base;      // High common base value.
    logic [7:0] bank_base;      // Bank area base value.
    logic [7:0] base;           // Selected base value.
    mmu_pkg::area_t sel;        // Selected logical area.

    // The translation unit supplies the page and the registers.
    modport unit (output nibble, output area, output high_base, output bank_base,
                  input base, input sel);
    // The comparator answers with the area and its base.
    modport cmp (input nibble, input area, input high_base, input bank_base,
                 output base, output sel);
endinterface

`default_nettype wire

// ===== rtl/area_compare.sv
// Comparator that classifies a logical page into one of three areas.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_map.svh"

module area_compare (
    mmu_xlate_if.cmp xl // Page in, area and base out.
);

    // Purely combinational so that the lookup costs no extra cycle.
    always_comb begin
        if (xl.nibble >= xl.area[`MMU_HI_START_MSB:`MMU_HI_START_LSB]) begin
            // High common area wins over the bank area when both starts are passed.
            xl.sel = mmu_pkg::AREA_HIGH_COMMON;
            xl.base = xl.high_base;
        end else if (xl.nibble >= xl.area[`MMU_BANK_START_MSB:`MMU_BANK_START_LSB]) begin
            // Between the two starts lies the bank area.
            xl.sel = mmu_pkg::AREA_BANK;
            xl.base = xl.bank_base;
        end else begin
            // Everything below both the bank start and the high start is the low common area, never relocated.
            xl.sel = mmu_pkg::AREA_LOW_COMMON;
            xl.base = `MMU_LOW_BASE;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/logical_to_physical_mmu.sv
// Logical to physical address translation unit with its two base registers and its area boundary register.
//
// Contract
// - Map 16-bit logical onto 20-bit physical addresses.
// - Up to three logical areas exist.
// - Area boundaries step in 4K logical pages.
// - Translate every kind of memory cycle.
// - I/O addresses pass through untranslated.
// - Top four address lines zero during I/O.
// - Block mover drives its 20-bit address directly.
// - Comparators pick the area from boundary register.
// - Add area base to upper logical nibble.
// - High common area uses high common base.
// - Low common area maps from physical zero.
// - Translation adds no extra bus cycles.
// - High common base register, I/O 38h, resets zero.
// - Bank base register, I/O 39h, resets zero.
// - Boundary register 3Ah, resets upper ones, lower zeros.
`timescale 1ns/1ps
`default_nettype none
`include "mmu_map.svh"

module logical_to_physical_mmu (
    input wire logic clk,                 // System clock, 200 MHz.
    input wire logic nrst,                // Synchronous reset, active low.
    input wire logic [15:0] cpu_addr,     // Logical address of the current cycle.
    input wire logic mem_cycle,           // Processor memory cycle of any kind.
    input wire logic io_cycle,            // Processor I/O cycle.
    input wire logic block_mover_own,     // On-chip block mover owns the bus.
    input wire logic [19:0] mover_addr,   // Block mover physical address.
    input wire logic io_wr,               // I/O write strobe for register writes.
    input wire logic io_rd,               // I/O read strobe for register reads.
    input wire logic [7:0] io_wdata,      // I/O write data.
    output logic [19:0] phys_addr,        // Physical address bus.
    output logic [7:0] io_rdata,          // Register read data.
    output logic io_rvalid                // Read data valid pulse.
);

    // Registered state and its next value.
    mmu_pkg::mmu_state_t state_q;
    mmu_pkg::mmu_state_t state_d;

    // Comparator link.
    mmu_xlate_if xl ();

    // Upper logical nibble, the 4K page number.
    logic [3:0] page;

    // The page is what the comparators look at, so boundaries move in 4K steps.
    assign page = cpu_addr[`MMU_PAGE_MSB:`MMU_PAGE_LSB];

    // Feed the comparator with the page and the live register contents.
    assign xl.nibble = page;
    assign xl.area = state_q.area;
    assign xl.high_base = state_q.high_base;
    assign xl.bank_base = state_q.bank_base;

    // The comparator decides among the low common, bank and high common areas.
    area_compare u_cmp (
        .xl(xl)
    );

    // Next state: address selection by cycle type plus register access.
    always_comb begin
        state_d = state_q;
        // The valid flag is a pulse, dropped unless a mapped read occurs.
        state_d.rvalid = 1'b0;
        if (block_mover_own) begin
            // Mover cycles bypass the unit entirely and take its own address.
            state_d.phys = mover_addr;
        end else if (io_cycle) begin
            // I/O cycles carry the logical address with a zero top nibble.
            state_d.phys = {`MMU_IO_TOP, cpu_addr};
        end else if (mem_cycle) begin
            // Fetches, data, vector and restart cycles all look the same here.
            state_d.phys = {xl.base + {`MMU_NIB_PAD, page},
                            cpu_addr[`MMU_OFFS_MSB:`MMU_OFFS_LSB]};
        end else begin
            // Idle cycles hold the bus so it does not glitch between accesses.
            state_d.phys = state_q.phys;
        end
        // Register writes follow io_wr alone, without checking io_cycle; mover cycles are ignored.
        if (io_wr && !block_mover_own) begin
            case (cpu_addr)
                `MMU_HIGH_BASE_ADDR: begin
                    state_d.high_base = io_wdata;
                end
                `MMU_BANK_BASE_ADDR: begin
                    state_d.bank_base = io_wdata;
                end
                `MMU_AREA_ADDR: begin
                    state_d.area = io_wdata;
                end
                default: begin
                    // Other I/O addresses belong to other blocks.
                    state_d.area = state_q.area;
                end
            endcase
        end
        // Reads show the registers as they stood before this edge.
        if (io_rd && !block_mover_own) begin
            case (cpu_addr)
                `MMU_HIGH_BASE_ADDR: begin
                    state_d.rdata = state_q.high_base;
                    state_d.rvalid = 1'b1;
                end
                `MMU_BANK_BASE_ADDR: begin
                    state_d.rdata = state_q.bank_base;
                    state_d.rvalid = 1'b1;
                end
                `MMU_AREA_ADDR: begin
                    state_d.rdata = state_q.area;
                    state_d.rvalid = 1'b1;
                end
                default: begin
                    // Unmapped reads return nothing from this unit.
                    state_d.rdata = `MMU_DATA_RST;
                end
            endcase
        end
        // Synchronous reset puts every register at its defined value.
        if (!nrst) begin
            state_d.high_base = `MMU_HIGH_BASE_RST;
            state_d.bank_base = `MMU_BANK_BASE_RST;
            state_d.area = `MMU_AREA_RST;
            state_d.phys = `MMU_PHYS_RST;
            state_d.rdata = `MMU_DATA_RST;
            state_d.rvalid = 1'b0;
        end
    end

    // One register stage; the address reaches the bus one clock after the cycle that presents it.
    // The register keeps outputs glitch free at the cost of one clock of latency,
    // which the bus timing of a processor cycle absorbs without a wait state.
    always_ff @(posedge clk) begin
        state_q <= state_d;
    end

    // Outputs straight from the state register.
    assign phys_addr = state_q.phys;
    assign io_rdata = state_q.rdata;
    assign io_rvalid = state_q.rvalid;

    // Checks on the translation.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    AST_IO_TOP_ZERO: assert property (
        (io_cycle && !block_mover_own) |=> (phys_addr[19:16] == 4'h0))
        else $error("I/O cycle drove a nonzero top nibble");

    AST_IO_PASS: assert property (
        (io_cycle && !block_mover_own) |=> (phys_addr[15:0] == $past(cpu_addr)))
        else $error("I/O address was altered");

    AST_MOVER_DIRECT: assert property (
        block_mover_own |=> (phys_addr == $past(mover_addr)))
        else $error("Block mover address was not passed directly");

    AST_OFFSET_PASS: assert property (
        (mem_cycle && !io_cycle && !block_mover_own)
        |=> (phys_addr[11:0] == $past(cpu_addr[11:0])))
        else $error("Low twelve address bits were altered");

    AST_HIGH_AREA: assert property (
        (mem_cycle && !io_cycle && !block_mover_own && (page >= state_q.area[7:4]))
        |=> (phys_addr[19:12] == $past(state_q.high_base) + {4'h0, $past(page)}))
        else $error("High common area not relocated by its base");

    AST_BANK_AREA: assert property (
        (mem_cycle && !io_cycle && !block_mover_own && (page < state_q.area[7:4])
         && (page >= state_q.area[3:0]))
        |=> (phys_addr[19:12] == $past(state_q.bank_base) + {4'h0, $past(page)}))
        else $error("Bank area not relocated by its base");

    AST_LOW_AREA: assert property (
        (mem_cycle && !io_cycle && !block_mover_own && (page < state_q.area[7:4])
         && (page < state_q.area[3:0]))
        |=> (phys_addr[19:12] == {4'h0, $past(page)}))
        else $error("Low common area was relocated");

    // The default disable would mute this check exactly while reset is low, so it opts out.
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (1'b0)
        !nrst |=> (state_q.area == `MMU_AREA_RST && state_q.high_base == `MMU_HIGH_BASE_RST
                   && state_q.bank_base == `MMU_BANK_BASE_RST && !io_rvalid))
        else $error("Registers not at reset values");

    AST_WRITE_HIGH: assert property (
        (io_wr && !block_mover_own && cpu_addr == 16'h0038)
        |=> (state_q.high_base == $past(io_wdata)))
        else $error("High common base write lost");

    AST_READ_AREA: assert property (
        (io_rd && !io_wr && !block_mover_own && cpu_addr == 16'h003A)
        |=> (io_rvalid && io_rdata == $past(state_q.area)) ##1 (!io_rvalid || $past(io_rd)) [*1])
        else $error("Boundary register readback wrong");

    // Idle cycles must leave the bus still; a stray change would look like a new access.
    AST_IDLE_HOLD: assert property (
        (!mem_cycle && !io_cycle && !block_mover_own) |=> $stable(phys_addr))
        else $error("Physical address moved during an idle cycle");

    // Mover cycles must never reach the translation registers.
    AST_MOVER_NO_WRITE: assert property (
        (block_mover_own && io_wr) |=> ($stable(state_q.high_base) && $stable(state_q.bank_base)
                                        && $stable(state_q.area)))
        else $error("Block mover cycle changed a translation register");

    // A bank base write lands at the very next edge.
    AST_WRITE_BANK: assert property (
        (io_wr && !block_mover_own && cpu_addr == `MMU_BANK_BASE_ADDR)
        |=> (state_q.bank_base == $past(io_wdata)))
        else $error("Bank base write lost");

    // The high common comparison outranks the bank comparison.
    AST_AREA_ORDER: assert property (
        (page >= state_q.area[`MMU_HI_START_MSB:`MMU_HI_START_LSB])
        |-> (xl.sel == mmu_pkg::AREA_HIGH_COMMON))
        else $error("High common area not chosen first");

    // Whatever the comparator calls low common must not be relocated.
    AST_LOW_SEL: assert property (
        (mem_cycle && !io_cycle && !block_mover_own && xl.sel == mmu_pkg::AREA_LOW_COMMON)
        |=> (phys_addr[19:12] == {`MMU_NIB_PAD, $past(page)}))
        else $error("Comparator low common choice was relocated");

endmodule

`default_nettype wire

// ===== test/cpu_core_model.sv
// Processor core model that issues memory, I/O and block mover cycles.
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
    input wire logic clk,              // System clock.
    output logic [15:0] cpu_addr,      // Logical address.
    output logic mem_cycle,            // Memory cycle.
    output logic io_cycle,             // I/O cycle.
    output logic block_mover_own,      // Mover owns the bus.
    output logic [19:0] mover_addr,    // Mover address.
    output logic io_wr,                // Register write strobe.
    output logic io_rd,                // Register read strobe.
    output logic [7:0] io_wdata        // Register write data.
);
    // Every line starts quiet so the block sees defined inputs at time zero.
    initial begin
        {cpu_addr, mem_cycle, io_cycle, block_mover_own} = 19'h00000;
        {mover_addr, io_wr, io_rd, io_wdata} = 30'h00000000;
    end

    // One cycle of any kind, launched at the falling edge and held a full period.
    task automatic drive(input logic m, input logic i, input logic v, input logic [15:0] a,
                         input logic [19:0] ma, input logic w, input logic r,
                         input logic [7:0] d);
        @(negedge clk);
        {mem_cycle, io_cycle, block_mover_own, io_wr, io_rd} = {m, i, v, w, r};
        cpu_addr = a;
        mover_addr = ma;
        io_wdata = d;
    endtask

    // Strobes drop; address and data lines show the inverse of their last value, never a stale copy.
    task automatic idle();
        @(negedge clk);
        {mem_cycle, io_cycle, block_mover_own, io_wr, io_rd} = 5'h00;
        cpu_addr = ~cpu_addr;
        mover_addr = ~mover_addr;
        io_wdata = ~io_wdata;
    endtask
endmodule

`default_nettype wire

// ===== test/logical_to_physical_mmu_test.sv
// Self-checking testbench of the address translation unit.
`timescale 1ns/1ps
`default_nettype none

module logical_to_physical_mmu_test;
    logic clk; // System clock.
    logic nrst; // Synchronous reset, active low.
    logic [15:0] cpu_addr; // Logical address.
    logic mem_cycle, io_cycle, block_mover_own, io_wr, io_rd, io_rvalid; // Strobes.
    logic [19:0] mover_addr, phys_addr; // Mover and physical address.
    logic [7:0] io_wdata, io_rdata; // Register data.
    logic [7:0] hb, bb, ar; // Expected register contents.
    int fails = 0; // Mismatch count.
    int n_checks = 0; // Comparison count.

    // Clock of 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    cpu_core_model cpu_u (.clk(clk), .cpu_addr(cpu_addr), .mem_cycle(mem_cycle),
        .io_cycle(io_cycle), .block_mover_own(block_mover_own), .mover_addr(mover_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

    logical_to_physical_mmu dut_u (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr),
        .mem_cycle(mem_cycle), .io_cycle(io_cycle), .block_mover_own(block_mover_own),
        .mover_addr(mover_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .phys_addr(phys_addr), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

    // Verdict and end of run.
    task automatic results();
        if (fails == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Compare tasks, one for each width of result.
    task automatic cmp_addr(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %05h expected %05h", $time, got, exp);
        end
    endtask
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_addr({12'h000, got}, {12'h000, exp});
    endtask

    // Expected translation, reckoned from the expected register copies.
    function automatic logic [19:0] expect_phys(input logic [15:0] a);
        logic [7:0] base;
        if (a[15:12] >= ar[7:4]) base = hb;
        else if (a[15:12] >= ar[3:0]) base = bb;
        else base = 8'h00;
        return {base + {4'h0, a[15:12]}, a[11:0]};
    endfunction

    // Register write as one I/O cycle.
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        cpu_u.drive(1'b0, 1'b1, 1'b0, a, 20'h00000, 1'b1, 1'b0, d);
    endtask

    // Register read; the valid pulse must last exactly one cycle.
    task automatic reg_chk(input logic [15:0] a, input logic [7:0] exp, input logic v);
        cpu_u.drive(1'b0, 1'b1, 1'b0, a, 20'h00000, 1'b0, 1'b1, 8'h00);
        cpu_u.idle();
        cmp_byte({7'h00, io_rvalid}, {7'h00, v});
        cmp_byte(io_rdata, exp);
        cpu_u.idle();
        cmp_byte({7'h00, io_rvalid}, 8'h00);
    endtask

    // Reset contents, then a top page access that lands in the high area.
    task automatic t_reset();
        reg_chk(16'h0038, 8'h00, 1'b1);
        reg_chk(16'h0039, 8'h00, 1'b1);
        reg_chk(16'h003A, 8'hF0, 1'b1);
        cpu_u.drive(1'b1, 1'b0, 1'b0, 16'hF123, 20'h00000, 1'b0, 1'b0, 8'h00);
        cpu_u.idle();
        cmp_addr(phys_addr, 20'h0F123);
        cpu_u.idle();
        cmp_addr(phys_addr, 20'h0F123);
    endtask

    // All sixteen pages back to back under one boundary setting.
    task automatic t_pages(input logic [7:0] h, input logic [7:0] b, input logic [7:0] a);
        logic [15:0] prev;
        reg_wr(16'h0038, h);
        reg_wr(16'h0039, b);
        reg_wr(16'h003A, a);
        {hb, bb, ar} = {h, b, a};
        prev = 16'h0C3A;
        cpu_u.drive(1'b1, 1'b0, 1'b0, prev, 20'h00000, 1'b0, 1'b0, 8'h00);
        for (int p = 1; p < 17; p++) begin
            if (p < 16) cpu_u.drive(1'b1, 1'b0, 1'b0, {p[3:0], 12'hC3A}, 20'h00000,
                                    1'b0, 1'b0, 8'h00);
            else cpu_u.idle();
            cmp_addr(phys_addr, expect_phys(prev));
            prev = {p[3:0], 12'hC3A};
        end
        reg_chk(16'h003A, a, 1'b1);
        reg_chk(16'h0039, b, 1'b1);
        reg_chk(16'h0038, h, 1'b1);
    endtask

    // Reset in mid-run puts the registers back at their reset values.
    task automatic t_rerst();
        @(negedge clk);
        nrst = 1'b0;
        {hb, bb, ar} = 24'h0000F0;
        @(negedge clk);
        nrst = 1'b1;
        reg_chk(16'h0038, 8'h00, 1'b1);
        reg_chk(16'h0039, 8'h00, 1'b1);
        reg_chk(16'h003A, 8'hF0, 1'b1);
        cpu_u.drive(1'b1, 1'b0, 1'b0, 16'h7456, 20'h00000, 1'b0, 1'b0, 8'h00);
        cpu_u.idle();
        cmp_addr(phys_addr, expect_phys(16'h7456));
    endtask

    // I/O cycles pass unchanged and win over a memory cycle.
    task automatic t_io();
        cpu_u.drive(1'b0, 1'b1, 1'b0, 16'hABCD, 20'h00000, 1'b0, 1'b0, 8'h00);
        cpu_u.drive(1'b1, 1'b1, 1'b0, 16'hFEDC, 20'h00000, 1'b0, 1'b0, 8'h00);
        cmp_addr(phys_addr, 20'h0ABCD);
        cpu_u.idle();
        cmp_addr(phys_addr, 20'h0FEDC);
    endtask

    // Mover address wins, and mover cycles cannot reach the registers.
    task automatic t_mover();
        cpu_u.drive(1'b1, 1'b0, 1'b1, 16'h0038, 20'h5A5A5, 1'b1, 1'b0, 8'h77);
        cpu_u.drive(1'b0, 1'b1, 1'b1, 16'h0039, 20'hA5A5A, 1'b0, 1'b1, 8'h00);
        cmp_addr(phys_addr, 20'h5A5A5);
        cpu_u.idle();
        cmp_addr(phys_addr, 20'hA5A5A);
        cmp_byte({7'h00, io_rvalid}, 8'h00);
        reg_chk(16'h0038, hb, 1'b1);
    endtask

    // Main sequence.
    initial begin
        nrst = 1'b0;
        {hb, bb, ar} = 24'h0000F0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_pages(8'hA0, 8'h35, 8'h84);
        t_pages(8'hFF, 8'h12, 8'h00);
        t_pages(8'h07, 8'hC0, 8'hF3);
        t_pages(8'h10, 8'h20, 8'h48);
        t_io();
        t_mover();
        reg_chk(16'h003B, 8'h00, 1'b0);
        reg_chk(16'h0138, 8'h00, 1'b0);
        t_rerst();
        results();
    end

    // Watchdog far beyond the fewer than two hundred cycles the tests need.
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule

`default_nettype wire
